//--- pkg/isr_pkg.sv
// isr_pkg: constants, command codes and carrier types for the instrument status block.
// assumes a single clock domain; all event sources are produced by logic on that clock.
package isr_pkg;

	localparam int EV_W = 8;
	localparam int COND_W = 16;

	// sync/error event bit positions
	localparam int SE_OPC = 0;
	localparam int SE_REQ_CTRL = 1;
	localparam int SE_QUERY = 2;
	localparam int SE_DEVICE = 3;
	localparam int SE_EXEC = 4;
	localparam int SE_COMMAND = 5;
	localparam int SE_PWR_ON = 7;

	// operation condition bit positions
	localparam int OC_CAL = 0;
	localparam int OC_SETTLE = 1;
	localparam int OC_RANGE = 2;
	localparam int OC_SWEEP = 3;
	localparam int OC_MEAS = 4;
	localparam int OC_WAIT_TRIG = 5;
	localparam int OC_WAIT_ARM = 6;
	localparam int OC_AVG = 8;
	localparam int OC_HARDCOPY = 9;
	localparam int OC_WATERFALL = 11;
	localparam int OC_CAPTURE = 12;
	localparam int OC_PROGRAM = 14;

	// user set: top bit is unimplemented
	localparam int USR_TOP = 15;
	localparam logic [COND_W-1:0] USR_IMPL_MASK = 16'h7fff;

	// summary bit positions in the status byte
	localparam int SB_USER = 0;
	localparam int SB_SYNC = 5;
	localparam int SB_OP = 7;

	// reset values
	localparam logic [EV_W-1:0] SYNC_MASK_RST = 8'h00;
	localparam logic [COND_W-1:0] OP_MASK_RST = 16'h0000;
	localparam logic [COND_W-1:0] USR_MASK_RST = 16'h0000;
	localparam logic [COND_W-1:0] USR_COND_RST = 16'h0000;

	typedef enum logic [3:0] {
		CMD_RD_SYNC_EVENT = 4'h0,
		CMD_WR_SYNC_MASK = 4'h1,
		CMD_RD_SYNC_MASK = 4'h2,
		CMD_RD_OP_COND = 4'h3,
		CMD_RD_OP_EVENT = 4'h4,
		CMD_WR_OP_MASK = 4'h5,
		CMD_RD_OP_MASK = 4'h6,
		CMD_WR_USER_COND = 4'h7,
		CMD_RD_USER_COND = 4'h8,
		CMD_USER_PULSE = 4'h9,
		CMD_RD_USER_EVENT = 4'ha,
		CMD_WR_USER_MASK = 4'hb,
		CMD_RD_USER_MASK = 4'hc,
		CMD_CLEAR_STATUS = 4'hd,
		CMD_RD_STATUS_BYTE = 4'he
	} isr_cmd_op_t;

	typedef enum logic [2:0] {
		MS_PAUSED,
		MS_AVG_DONE,
		MS_WAIT_INIT,
		MS_SETTLE,
		MS_WAIT_ARM,
		MS_WAIT_TRIG,
		MS_RUNNING
	} isr_meas_state_t;

	typedef struct packed {
		isr_cmd_op_t op;
		logic [COND_W-1:0] data;
	} isr_cmd_t;

	typedef struct packed {
		logic opc_cmd;
		logic ops_pending;
		logic addr_only;
		logic bus_ctrl_req;
		logic err_query;
		logic err_device;
		logic err_exec;
		logic err_command;
	} isr_sync_src_t;

	typedef struct packed {
		isr_meas_state_t state;
		logic sweep_cont;
		logic scan_end;
		logic calibrating;
		logic hw_settling;
		logic autoranging;
		logic arm_src_ext;
		logic avg_active;
		logic avg_exp;
		logic avg_count_met;
		logic hardcopy_busy;
		logic wfall_active;
		logic wfall_done;
		logic capture_start;
		logic capture_stop;
		logic prog_running;
	} isr_meas_src_t;

endpackage : isr_pkg

//--- rtl/isr_event_latch.sv
// isr_event_latch: per-bit rising-edge event latch with clear.
// assumes cond comes from logic on clk_sys; clr is a one-cycle strobe.
`timescale 1ns/10ps
module isr_event_latch #(
	parameter int W = 8
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [W-1:0] cond,
	input wire logic clr,
	output logic [W-1:0] rise,
	output logic [W-1:0] event_ff
);

	logic [W-1:0] prev_ff;

	for (genvar i = 0; i < W; i++) begin : g_bit
		assign rise[i] = cond[i] & ~prev_ff[i];
		always_ff @(posedge clk_sys or negedge arst_n) begin
			if (!arst_n) begin
				prev_ff[i] <= 1'b0;
				event_ff[i] <= 1'b0;
			end else begin
				prev_ff[i] <= cond[i];
				// a new edge in the clearing cycle is kept
				event_ff[i] <= rise[i] | (event_ff[i] & ~clr);
			end
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	// the reset-release edge is skipped: rise may be high there while the latch still sits in reset
	chk_rise_sets_bit: assert property ((arst_n && (|rise)) |=> ((event_ff & $past(rise)) == $past(rise)))
		else $error("rising condition did not latch");
	chk_clear_empties: assert property (clr && !(|rise) |=> event_ff == '0)
		else $error("clear left event bits set");

endmodule : isr_event_latch

//--- rtl/isr_status_core.sv
// isr_status_core: sync/error event set, operation status set, user status set and their summaries.
// assumes one command per cycle at most on cmd_valid/cmd, and event sources synchronous to clk_sys.
`timescale 1ns/10ps
module isr_status_core (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic cmd_valid,
	input wire isr_pkg::isr_cmd_t cmd,
	input wire isr_pkg::isr_sync_src_t sync_src,
	input wire isr_pkg::isr_meas_src_t meas_src,
	input wire logic trig_in,
	output logic rsp_valid_ff,
	output logic [isr_pkg::COND_W-1:0] rsp_data_ff,
	output logic [7:0] status_summary_ff,
	output logic [isr_pkg::COND_W-1:0] operation_condition_ff,
	output logic trig_accept_ff
);

	localparam int EW = isr_pkg::EV_W;
	localparam int CW = isr_pkg::COND_W;

	logic pwr_on_ff;
	logic opc_armed_ff;
	logic capture_ff;
	logic [EW-1:0] sync_error_event_mask_ff;
	logic [CW-1:0] op_mask_ff;
	logic [CW-1:0] user_mask_ff;
	logic [CW-1:0] user_pulse_condition_ff;
	logic [CW-1:0] user_strobe_ff;

	logic [EW-1:0] sync_cond;
	logic [EW-1:0] sync_rise;
	logic [EW-1:0] sync_error_event_latch;
	logic [CW-1:0] nxt_op_cond;
	logic [CW-1:0] op_rise;
	logic [CW-1:0] op_event;
	logic [CW-1:0] user_cond;
	logic [CW-1:0] user_rise;
	logic [CW-1:0] user_event;
	logic clr_all;
	logic clr_sync;
	logic clr_op;
	logic clr_user;
	logic opc_fire;
	logic meas_bit;
	logic sweep_bit;
	logic in_sweep_state;
	logic [CW-1:0] nxt_rsp_data;
	logic [7:0] nxt_summary;

	assign clr_all = cmd_valid && cmd.op == isr_pkg::CMD_CLEAR_STATUS;
	assign clr_sync = clr_all || (cmd_valid && cmd.op == isr_pkg::CMD_RD_SYNC_EVENT);
	assign clr_op = clr_all || (cmd_valid && cmd.op == isr_pkg::CMD_RD_OP_EVENT);
	assign clr_user = clr_all || (cmd_valid && cmd.op == isr_pkg::CMD_RD_USER_EVENT);

	// sync / error set
	// power-on condition is high during reset and in the first cycle after reset release
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pwr_on_ff <= 1'b1;
		end else begin
			pwr_on_ff <= 1'b0;
		end
	end

	assign opc_fire = opc_armed_ff && !sync_src.ops_pending;

	// operation-complete waits until every overlapped command is done
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			opc_armed_ff <= 1'b0;
		end else if (sync_src.opc_cmd) begin
			opc_armed_ff <= 1'b1;
		end else if (opc_fire || clr_all) begin
			opc_armed_ff <= 1'b0;
		end
	end

	always_comb begin
		sync_cond = '0;
		sync_cond[isr_pkg::SE_OPC] = opc_fire;
		sync_cond[isr_pkg::SE_REQ_CTRL] = sync_src.addr_only && sync_src.bus_ctrl_req;
		sync_cond[isr_pkg::SE_QUERY] = sync_src.err_query;
		sync_cond[isr_pkg::SE_DEVICE] = sync_src.err_device;
		sync_cond[isr_pkg::SE_EXEC] = sync_src.err_exec;
		sync_cond[isr_pkg::SE_COMMAND] = sync_src.err_command;
		sync_cond[isr_pkg::SE_PWR_ON] = pwr_on_ff;
	end

	// no condition or transition register is kept for this set
	isr_event_latch #(.W(EW)) u_sync_latch (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.cond(sync_cond),
		.clr(clr_sync),
		.rise(sync_rise),
		.event_ff(sync_error_event_latch)
	);

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sync_error_event_mask_ff <= isr_pkg::SYNC_MASK_RST;
		end else if (cmd_valid && cmd.op == isr_pkg::CMD_WR_SYNC_MASK) begin
			sync_error_event_mask_ff <= cmd.data[EW-1:0];
		end
	end

	// operation status set
	assign in_sweep_state = meas_src.state inside {isr_pkg::MS_SETTLE, isr_pkg::MS_WAIT_ARM,
		isr_pkg::MS_WAIT_TRIG, isr_pkg::MS_RUNNING};
	// measuring covers the abort-to-arm/trigger waits and the single-sweep init wait
	assign meas_bit = (in_sweep_state || meas_src.state == isr_pkg::MS_WAIT_INIT)
		&& !meas_src.scan_end;
	assign sweep_bit = meas_src.sweep_cont ? meas_bit : (in_sweep_state && !meas_src.scan_end);

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			capture_ff <= 1'b0;
		end else if (meas_src.capture_start) begin
			capture_ff <= 1'b1;
		end else if (meas_src.capture_stop) begin
			capture_ff <= 1'b0;
		end
	end

	always_comb begin
		nxt_op_cond = '0;
		nxt_op_cond[isr_pkg::OC_CAL] = meas_src.calibrating;
		nxt_op_cond[isr_pkg::OC_SETTLE] = meas_src.hw_settling;
		nxt_op_cond[isr_pkg::OC_RANGE] = meas_src.autoranging;
		nxt_op_cond[isr_pkg::OC_SWEEP] = sweep_bit;
		nxt_op_cond[isr_pkg::OC_MEAS] = meas_bit;
		nxt_op_cond[isr_pkg::OC_WAIT_TRIG] = meas_src.state == isr_pkg::MS_WAIT_TRIG;
		nxt_op_cond[isr_pkg::OC_WAIT_ARM] = meas_src.arm_src_ext
			&& meas_src.state == isr_pkg::MS_WAIT_ARM;
		// exponential averaging holds until the count is met, then mirrors measuring
		nxt_op_cond[isr_pkg::OC_AVG] = meas_src.avg_exp
			? (!meas_src.avg_count_met || meas_bit) : meas_src.avg_active;
		nxt_op_cond[isr_pkg::OC_HARDCOPY] = meas_src.hardcopy_busy;
		nxt_op_cond[isr_pkg::OC_WATERFALL] = meas_src.wfall_active
			&& (!meas_src.wfall_done || meas_bit);
		nxt_op_cond[isr_pkg::OC_CAPTURE] = capture_ff;
		nxt_op_cond[isr_pkg::OC_PROGRAM] = meas_src.prog_running;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			operation_condition_ff <= '0;
		end else begin
			operation_condition_ff <= nxt_op_cond;
		end
	end

	// triggers are only honoured once the waiting bit is visible to software
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			trig_accept_ff <= 1'b0;
		end else begin
			trig_accept_ff <= trig_in && operation_condition_ff[isr_pkg::OC_WAIT_TRIG];
		end
	end

	isr_event_latch #(.W(CW)) u_op_latch (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.cond(operation_condition_ff),
		.clr(clr_op),
		.rise(op_rise),
		.event_ff(op_event)
	);

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			op_mask_ff <= isr_pkg::OP_MASK_RST;
		end else if (cmd_valid && cmd.op == isr_pkg::CMD_WR_OP_MASK) begin
			op_mask_ff <= cmd.data;
		end
	end

	// user status set
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			user_pulse_condition_ff <= isr_pkg::USR_COND_RST;
		end else if (cmd_valid && cmd.op == isr_pkg::CMD_WR_USER_COND) begin
			user_pulse_condition_ff <= cmd.data & isr_pkg::USR_IMPL_MASK;
		end
	end

	// one-cycle strobe: bits rest at zero between pulse commands
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			user_strobe_ff <= '0;
		end else if (cmd_valid && cmd.op == isr_pkg::CMD_USER_PULSE) begin
			user_strobe_ff <= cmd.data & isr_pkg::USR_IMPL_MASK;
		end else begin
			user_strobe_ff <= '0;
		end
	end

	assign user_cond = user_pulse_condition_ff | user_strobe_ff;

	// fixed rising-only transition filter; falling edges never latch
	isr_event_latch #(.W(CW)) u_user_latch (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.cond(user_cond),
		.clr(clr_user),
		.rise(user_rise),
		.event_ff(user_event)
	);

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			user_mask_ff <= isr_pkg::USR_MASK_RST;
		end else if (cmd_valid && cmd.op == isr_pkg::CMD_WR_USER_MASK) begin
			user_mask_ff <= cmd.data & isr_pkg::USR_IMPL_MASK;
		end
	end

	// summaries
	always_comb begin
		nxt_summary = '0;
		nxt_summary[isr_pkg::SB_USER] = |(user_event & user_mask_ff);
		nxt_summary[isr_pkg::SB_SYNC] = |(sync_error_event_latch & sync_error_event_mask_ff);
		nxt_summary[isr_pkg::SB_OP] = |(op_event & op_mask_ff);
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			status_summary_ff <= '0;
		end else begin
			status_summary_ff <= nxt_summary;
		end
	end

	// command answers
	always_comb begin
		nxt_rsp_data = '0;
		unique case (cmd.op)
			isr_pkg::CMD_RD_SYNC_EVENT: nxt_rsp_data = {8'h00, sync_error_event_latch};
			isr_pkg::CMD_RD_SYNC_MASK: nxt_rsp_data = {8'h00, sync_error_event_mask_ff};
			isr_pkg::CMD_RD_OP_COND: nxt_rsp_data = operation_condition_ff;
			isr_pkg::CMD_RD_OP_EVENT: nxt_rsp_data = op_event;
			isr_pkg::CMD_RD_OP_MASK: nxt_rsp_data = op_mask_ff;
			isr_pkg::CMD_RD_USER_COND: nxt_rsp_data = '0;
			isr_pkg::CMD_RD_USER_EVENT: nxt_rsp_data = user_event & isr_pkg::USR_IMPL_MASK;
			isr_pkg::CMD_RD_USER_MASK: nxt_rsp_data = user_mask_ff;
			isr_pkg::CMD_RD_STATUS_BYTE: nxt_rsp_data = {8'h00, status_summary_ff};
			isr_pkg::CMD_WR_SYNC_MASK, isr_pkg::CMD_WR_OP_MASK, isr_pkg::CMD_WR_USER_COND,
			isr_pkg::CMD_USER_PULSE, isr_pkg::CMD_WR_USER_MASK,
			isr_pkg::CMD_CLEAR_STATUS: nxt_rsp_data = '0;
			default: nxt_rsp_data = '0;
		endcase
	end

	// every command is acknowledged one cycle later; writes answer zero
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rsp_valid_ff <= 1'b0;
			rsp_data_ff <= '0;
		end else begin
			rsp_valid_ff <= cmd_valid;
			rsp_data_ff <= cmd_valid ? nxt_rsp_data : '0;
		end
	end

	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	// the flag falls one edge after release, by which time the event bit must already stand
	chk_power_on_latch: assert property ($fell(pwr_on_ff) |-> sync_error_event_latch[isr_pkg::SE_PWR_ON])
		else $error("power-on event not latched");
	chk_opc_after_pending: assert property (opc_armed_ff && !sync_src.ops_pending
		|=> sync_error_event_latch[isr_pkg::SE_OPC])
		else $error("operation complete not latched");
	chk_opc_holds_off: assert property (sync_src.ops_pending && !sync_error_event_latch[isr_pkg::SE_OPC]
		|=> !sync_error_event_latch[isr_pkg::SE_OPC])
		else $error("operation complete raised while work pending");
	chk_req_ctrl_latch: assert property ($rose(sync_src.addr_only && sync_src.bus_ctrl_req)
		|=> sync_error_event_latch[isr_pkg::SE_REQ_CTRL])
		else $error("request control not latched");
	chk_query_err_latch: assert property ($rose(sync_src.err_query)
		|=> sync_error_event_latch[isr_pkg::SE_QUERY])
		else $error("query error not latched");
	chk_sync_summary: assert property (1'b1 |=> status_summary_ff[isr_pkg::SB_SYNC]
		== $past(|(sync_error_event_latch & sync_error_event_mask_ff)))
		else $error("sync summary mismatch");
	chk_op_summary: assert property (1'b1 |=> status_summary_ff[isr_pkg::SB_OP]
		== $past(|(op_event & op_mask_ff)))
		else $error("operation summary mismatch");
	chk_user_summary: assert property (1'b1 |=> status_summary_ff[isr_pkg::SB_USER]
		== $past(|(user_event & user_mask_ff)))
		else $error("user summary mismatch");
	chk_trig_gated: assert property (trig_accept_ff |-> $past(trig_in)
		&& $past(operation_condition_ff[isr_pkg::OC_WAIT_TRIG]))
		else $error("trigger accepted before ready");
	chk_user_pulse_brief: assert property (cmd_valid && cmd.op == isr_pkg::CMD_USER_PULSE
		##1 !cmd_valid |=> user_strobe_ff == '0)
		else $error("user pulse held longer than one cycle");
	chk_user_top_zero: assert property (!user_event[isr_pkg::USR_TOP])
		else $error("user top bit set");
	chk_user_cond_hidden: assert property (cmd_valid && cmd.op == isr_pkg::CMD_RD_USER_COND
		|=> rsp_valid_ff && rsp_data_ff == '0)
		else $error("user condition readable");
	chk_capture_span: assert property (meas_src.capture_start |=> ##1
		operation_condition_ff[isr_pkg::OC_CAPTURE])
		else $error("capture bit not set");
	chk_meas_scan_drop: assert property (meas_src.scan_end |=> !operation_condition_ff[isr_pkg::OC_MEAS])
		else $error("measuring did not drop at scan end");
	chk_settle_bits: assert property (arst_n |=> operation_condition_ff[isr_pkg::OC_RANGE:isr_pkg::OC_CAL]
		== $past({meas_src.autoranging, meas_src.hw_settling, meas_src.calibrating}))
		else $error("calibrate, settle or range bit wrong");
	chk_wait_arm_gate: assert property (operation_condition_ff[isr_pkg::OC_WAIT_ARM]
		|-> $past(meas_src.arm_src_ext) && $past(meas_src.state) == isr_pkg::MS_WAIT_ARM)
		else $error("waiting-arm bit without external arm");
	chk_program_bit: assert property (arst_n |=> operation_condition_ff[isr_pkg::OC_PROGRAM]
		== $past(meas_src.prog_running))
		else $error("program bit wrong");

endmodule : isr_status_core

//--- tb/instrument_status_reporting_tb.sv
// instrument_status_reporting_tb: directed self-checking bench for the status core.
// assumes isr_ctrl_model as the command source; event and measurement sources are driven here.
`timescale 1ns/10ps
module instrument_status_reporting_tb;
	logic clk_sys;
	logic arst_n;
	logic cmd_valid;
	isr_pkg::isr_cmd_t cmd;
	isr_pkg::isr_sync_src_t sync_src;
	isr_pkg::isr_meas_src_t meas_src;
	logic trig_in;
	logic rsp_valid_ff;
	logic [15:0] rsp_data_ff;
	logic [7:0] status_summary_ff;
	logic [15:0] operation_condition_ff;
	logic trig_accept_ff;
	int num_errors;
	int comparisons;
	int cycles;
	logic [15:0] exp;

	isr_status_core DUT (.clk_sys(clk_sys), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd(cmd),
		.sync_src(sync_src), .meas_src(meas_src), .trig_in(trig_in), .rsp_valid_ff(rsp_valid_ff),
		.rsp_data_ff(rsp_data_ff), .status_summary_ff(status_summary_ff),
		.operation_condition_ff(operation_condition_ff), .trig_accept_ff(trig_accept_ff));

	isr_ctrl_model ctl (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd(cmd), .rsp_valid_ff(rsp_valid_ff),
		.rsp_data_ff(rsp_data_ff));

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [16:0] got, input logic [16:0] want);
		comparisons++;
		if (got !== want) begin
			num_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, want);
		end
	endtask : chk

	task automatic chk_sig(input logic [15:0] got, input logic [15:0] want);
		chk({1'b0, got}, {1'b0, want});
	endtask : chk_sig

	task automatic rd(input isr_pkg::isr_cmd_op_t op, input logic [15:0] want);
		logic [16:0] r;
		ctl.send(op, 16'h0000, r);
		chk(r, {1'b1, want});
	endtask : rd

	task automatic wr(input isr_pkg::isr_cmd_op_t op, input logic [15:0] data);
		logic [16:0] r;
		ctl.send(op, data, r);
		chk(r, {1'b1, 16'h0000});
	endtask : wr

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : wait_cyc

	// one-cycle high on a sync source field
	task automatic pulse_sync(input int idx);
		@(posedge clk_sys);
		sync_src[idx] <= 1'b1;
		@(posedge clk_sys);
		sync_src[idx] <= 1'b0;
	endtask : pulse_sync

	task automatic do_reset();
		@(posedge clk_sys);
		arst_n <= 1'b0;
		repeat (16) @(posedge clk_sys);
		arst_n <= 1'b1;
	endtask : do_reset

	task automatic complete_run();
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : complete_run

	// ceiling well above the roughly 160 cycles the sequence needs
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			num_errors++;
			$display("ERROR %0t: timeout", $time);
			complete_run();
		end
	end

	initial begin
		arst_n = 1'b0;
		sync_src = '0;
		meas_src = '0;
		trig_in = 1'b0;
		num_errors = 0;
		comparisons = 0;
		cycles = 0;
		do_reset();
		rd(isr_pkg::CMD_RD_SYNC_EVENT, 16'h0080);
		rd(isr_pkg::CMD_RD_SYNC_EVENT, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			pulse_sync(3 - i);
			rd(isr_pkg::CMD_RD_SYNC_EVENT, 16'h0004 << i);
		end
		$display("test power-on and parser errors done");
		@(posedge clk_sys);
		sync_src.ops_pending <= 1'b1;
		pulse_sync(7);
		rd(isr_pkg::CMD_RD_SYNC_EVENT, 16'h0000);
		@(posedge clk_sys);
		sync_src.ops_pending <= 1'b0;
		wait_cyc(3);
		rd(isr_pkg::CMD_RD_SYNC_EVENT, 16'h0001);
		@(posedge clk_sys);
		sync_src.bus_ctrl_req <= 1'b1;
		rd(isr_pkg::CMD_RD_SYNC_EVENT, 16'h0000);
		@(posedge clk_sys);
		sync_src.addr_only <= 1'b1;
		wait_cyc(2);
		rd(isr_pkg::CMD_RD_SYNC_EVENT, 16'h0002);
		sync_src <= '0;
		$display("test completion and bus control done");
		wr(isr_pkg::CMD_WR_SYNC_MASK, 16'hff10);
		rd(isr_pkg::CMD_RD_SYNC_MASK, 16'h0010);
		pulse_sync(2);
		wait_cyc(3);
		chk_sig({8'h00, status_summary_ff}, 16'h0000);
		pulse_sync(1);
		wait_cyc(3);
		chk_sig({8'h00, status_summary_ff}, 16'h0020);
		wr(isr_pkg::CMD_CLEAR_STATUS, 16'h0000);
		wait_cyc(2);
		chk_sig({8'h00, status_summary_ff}, 16'h0000);
		rd(isr_pkg::CMD_RD_SYNC_EVENT, 16'h0000);
		$display("test sync mask and summary done");
		@(posedge clk_sys);
		meas_src.arm_src_ext <= 1'b1;
		for (int s = 0; s < 7; s++) begin
			@(posedge clk_sys);
			meas_src.state <= isr_pkg::isr_meas_state_t'(s);
			wait_cyc(1);
			exp = {9'h000, s == 4, s == 5, s >= 2, s >= 3, 3'h0};
			chk_sig(operation_condition_ff, exp);
		end
		@(posedge clk_sys);
		meas_src.scan_end <= 1'b1;
		wait_cyc(1);
		chk_sig(operation_condition_ff, 16'h0000);
		meas_src.scan_end <= 1'b0;
		trig_in <= 1'b1;
		wait_cyc(1);
		chk_sig({15'h0000, trig_accept_ff}, 16'h0000);
		trig_in <= 1'b0;
		meas_src.state <= isr_pkg::MS_WAIT_TRIG;
		wait_cyc(1);
		trig_in <= 1'b1;
		wait_cyc(1);
		chk_sig({15'h0000, trig_accept_ff}, 16'h0001);
		trig_in <= 1'b0;
		meas_src.state <= isr_pkg::MS_WAIT_INIT;
		meas_src.sweep_cont <= 1'b1;
		wait_cyc(1);
		chk_sig(operation_condition_ff, 16'h0018);
		meas_src <= '0;
		@(posedge clk_sys);
		meas_src.state <= isr_pkg::MS_WAIT_ARM;
		{meas_src.calibrating, meas_src.hw_settling, meas_src.autoranging} <= 3'h7;
		{meas_src.hardcopy_busy, meas_src.prog_running} <= 2'h3;
		wait_cyc(1);
		chk_sig(operation_condition_ff, 16'h421f);
		$display("test operation condition done");
		meas_src <= '0;
		meas_src.avg_exp <= 1'b1;
		meas_src.wfall_active <= 1'b1;
		wait_cyc(1);
		chk_sig(operation_condition_ff, 16'h0900);
		meas_src.avg_count_met <= 1'b1;
		meas_src.wfall_done <= 1'b1;
		wait_cyc(1);
		chk_sig(operation_condition_ff, 16'h0000);
		meas_src <= '0;
		meas_src.capture_start <= 1'b1;
		@(posedge clk_sys);
		meas_src.capture_start <= 1'b0;
		wait_cyc(1);
		chk_sig(operation_condition_ff, 16'h1000);
		meas_src.capture_stop <= 1'b1;
		@(posedge clk_sys);
		meas_src.capture_stop <= 1'b0;
		wait_cyc(1);
		chk_sig(operation_condition_ff, 16'h0000);
		wr(isr_pkg::CMD_CLEAR_STATUS, 16'h0000);
		wr(isr_pkg::CMD_WR_OP_MASK, 16'h0001);
		rd(isr_pkg::CMD_RD_OP_MASK, 16'h0001);
		meas_src.calibrating <= 1'b1;
		wait_cyc(4);
		chk_sig({8'h00, status_summary_ff}, 16'h0080);
		rd(isr_pkg::CMD_RD_OP_EVENT, 16'h0001);
		meas_src.calibrating <= 1'b0;
		wait_cyc(3);
		chk_sig({8'h00, status_summary_ff}, 16'h0000);
		$display("test averaging, capture and operation summary done");
		wr(isr_pkg::CMD_WR_USER_MASK, 16'h0020);
		wr(isr_pkg::CMD_USER_PULSE, 16'h0020);
		wait_cyc(2);
		chk_sig({8'h00, status_summary_ff}, 16'h0001);
		rd(isr_pkg::CMD_RD_USER_EVENT, 16'h0020);
		rd(isr_pkg::CMD_RD_USER_EVENT, 16'h0000);
		rd(isr_pkg::CMD_RD_USER_COND, 16'h0000);
		wr(isr_pkg::CMD_USER_PULSE, 16'hffff);
		rd(isr_pkg::CMD_RD_USER_EVENT, 16'h7fff);
		rd(isr_pkg::isr_cmd_op_t'(4'hf), 16'h0000);
		$display("test user set done");
		do_reset();
		rd(isr_pkg::CMD_RD_SYNC_EVENT, 16'h0080);
		rd(isr_pkg::CMD_RD_SYNC_MASK, 16'h0000);
		rd(isr_pkg::CMD_RD_USER_MASK, 16'h0000);
		$display("test second reset done");
		complete_run();
	end
endmodule : instrument_status_reporting_tb

//--- tb/isr_ctrl_model.sv
// isr_ctrl_model: remote controller issuing status commands on the command port of the status core.
// assumes one command in flight at a time; the answer strobe comes one cycle after the command is taken.
`timescale 1ns/10ps
module isr_ctrl_model (
	input wire logic clk_sys,
	output logic cmd_valid,
	output isr_pkg::isr_cmd_t cmd,
	input wire logic rsp_valid_ff,
	input wire logic [isr_pkg::COND_W-1:0] rsp_data_ff
);
	initial begin
		cmd_valid = 1'b0;
		cmd = '{op: isr_pkg::CMD_RD_STATUS_BYTE, data: 16'h5a5a};
	end

	// rsp packs {answer strobe, answer data}
	task automatic send(input isr_pkg::isr_cmd_op_t op, input logic [15:0] data, output logic [16:0] rsp);
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd <= '{op: op, data: data};
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
		// released data is scrambled so nothing can lean on a stale value
		cmd.data <= ~data;
		#1;
		rsp = {rsp_valid_ff, rsp_data_ff};
	endtask : send
endmodule : isr_ctrl_model
